// ==== pkg/drt_pkg.sv ====
// Purpose: Constants and types for the DRAM refresh timer and refresh control block
// Assumes: AHB-Lite slave, 32-bit data, one word per register
// Notes: Byte addresses are the printed offsets times four, address bits 25:2 decoded
package drt_pkg;
    // ==========================================================
    // Register word indices (printed offsets are not word aligned, so byte address is index*4)
    localparam logic [23:0] DRT_IDX_COUNTER = 24'hff_fda8;
    localparam logic [23:0] DRT_IDX_CONSTANT = 24'hff_fda9;
    localparam logic [23:0] DRT_IDX_SYSCTL = 24'hff_fdc2;
    localparam logic [23:0] DRT_IDX_REFCTL = 24'hff_fdc0;
    localparam logic [23:0] DRT_IDX_IRQ_STATUS = 24'hff_fdc4;
    localparam logic [23:0] DRT_IDX_IRQ_CLEAR = 24'hff_fdc5;
    localparam logic [23:0] DRT_IDX_IRQ_ENABLE = 24'hff_fdc6;
    localparam logic [23:0] DRT_IDX_DRAMCTL = 24'hff_fdc8;
    localparam logic [23:0] DRT_IDX_STANDBY = 24'hff_fdc9;
    // ==========================================================
    // Field positions of refresh_control, system control and DRAM control
    localparam int DRT_F_MIE = 14;
    localparam int DRT_F_CKS = 8;
    localparam int DRT_F_RFE = 7;
    localparam int DRT_F_RLW = 4;
    localparam int DRT_F_SLF = 3;
    localparam int DRT_F_TPCS = 0;
    localparam int DRT_F_FLAG = 15;
    localparam int DRT_F_EXTERNAL_BUS_ENABLE = 9;
    localparam int DRT_F_TPC = 12;
    localparam int DRT_F_OEE = 0;
    // ==========================================================
    // Reset values
    localparam logic [7:0] DRT_RST_CONSTANT = 8'ha0;
    localparam logic [2:0] DRT_RST_CKS = 3'h1;
    localparam logic DRT_RST_RFE = 1'b1;
    // ==========================================================
    // Types
    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] haddr;
    } drt_ahb_req_t;

    typedef struct packed {
        logic refresh_req;
        logic self_refresh;
        logic [2:0] refresh_wait;
        logic [3:0] post_sr_precharge;
        logic ext_bus_en;
        logic cke_oe;
    } drt_mem_ctl_t;

    typedef enum logic [1:0] {
        DRT_MEM_RUN,
        DRT_MEM_REFRESH,
        DRT_MEM_SELFREF,
        DRT_MEM_PRECHG
    } drt_mem_state_t;
endpackage

// ==== rtl/drt_refresh_timer.sv ====
// Purpose: Refresh interval timer and refresh cycle control
// Assumes: Pin inputs synchronous to i_sys_clk; memory side answers o_refresh with i_refresh_done
// Notes: Divided clock selected by a prescaler; one refresh request per compare match while refresh is enabled
//
// Decided for this implementation: register access over AHB-Lite.
`timescale 1ns/100ps

// Function
// - The match interrupt enable gates whether a set match flag raises the interrupt.
// - While refresh is on the interrupt enable reads 0 and writes to it are ignored.
// - A 3-bit select chooses one of seven prescaled clocks, 001 being divide by 2, and code 000 stops counting.
// - Refresh enable turns refresh control on, and when off the counter is an interval timer.
// - A 3-bit wait field adds that many wait cycles to each refresh cycle.
// - With self-refresh enable, refresh on and the external bus enabled, standby entry puts memory into self-refresh.
// - The precharge after self-refresh lasts one cycle more than the post-self-refresh field plus the precharge field.
// - The counter counts prescaled ticks, and on a match it sets the flag and clears to zero.
// - Each match with refresh on and the external bus enabled issues a refresh cycle.
// - Each match with refresh off and interrupt enabled raises the match interrupt.
// - The constant register is compared with the counter on every count.
// - The external bus enable is 1 and fixed in expansion mode, and resets to 0 and is writable in single-chip mode.
// - External bus enable 0 disables the external bus and 1 enables it.
module drt_refresh_timer
    import drt_pkg::*;
(
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // AHB-Lite slave
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    // Mode and memory side
    input wire logic i_expansion_mode,
    input wire logic i_standby_req,
    input wire logic i_refresh_done,
    output logic o_refresh,
    output logic o_self_refresh,
    output logic o_precharge,
    output logic [2:0] o_refresh_wait,
    output logic o_ext_bus_en,
    output logic o_cke_oe,
    output logic o_irq
);
    // ==========================================================
    // Bus capture
    drt_ahb_req_t req_q;
    logic req_valid_q;
    logic wr_en;
    logic [23:0] wr_addr;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            req_valid_q <= 1'b0;
            req_q <= '0;
        end
        else if (i_hready)
        begin
            req_valid_q <= i_hsel && i_htrans[1];
            req_q <= '{htrans: i_htrans, hwrite: i_hwrite, hsize: i_hsize, haddr: i_haddr};
        end
    end

    // Zero-wait slave, always OKAY
    assign o_hreadyout = 1'b1;
    assign o_hresp = 1'b0;
    assign wr_en = req_valid_q && req_q.hwrite;
    assign wr_addr = req_q.haddr[25:2];

    // ==========================================================
    // Registers
    logic [7:0] counter_q;
    logic [7:0] constant_q;
    logic match_irq_enable_q;
    logic [2:0] clock_sel_q;
    logic refresh_enable_q;
    logic [2:0] refresh_wait_q;
    logic self_refresh_enable_q;
    logic [2:0] post_sr_precharge_q;
    logic [1:0] precharge_cycles_q;
    logic memory_output_enable_q;
    logic ext_bus_en_q;
    logic match_flag_q;
    logic irq_enable_q;
    logic [6:0] prescale_q;
    logic tick;
    logic match;

    // Prescaler: select n gives divide by 2^n
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            prescale_q <= '0;
        else
            prescale_q <= prescale_q + 7'h01;
    end

    always_comb
    begin
        tick = 1'b0;
        if (clock_sel_q != 3'h0)
            tick = (prescale_q & ((7'h01 << clock_sel_q) - 7'h01)) == 7'h00;
    end

    assign match = tick && (counter_q == constant_q);

    // Counter, software may write it
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            counter_q <= '0;
        else if (wr_en && wr_addr == DRT_IDX_COUNTER)
            counter_q <= i_hwdata[7:0];
        else if (match)
            counter_q <= 8'h00;
        else if (tick)
            counter_q <= counter_q + 8'h01;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            constant_q <= DRT_RST_CONSTANT;
        else if (wr_en && wr_addr == DRT_IDX_CONSTANT)
            constant_q <= i_hwdata[7:0];
    end

    // Refresh control fields
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            match_irq_enable_q <= 1'b0;
            clock_sel_q <= DRT_RST_CKS;
            refresh_enable_q <= DRT_RST_RFE;
            refresh_wait_q <= '0;
            self_refresh_enable_q <= 1'b0;
            post_sr_precharge_q <= '0;
        end
        else if (wr_en && wr_addr == DRT_IDX_REFCTL)
        begin
            clock_sel_q <= i_hwdata[DRT_F_CKS+:3];
            refresh_enable_q <= i_hwdata[DRT_F_RFE];
            refresh_wait_q <= i_hwdata[DRT_F_RLW+:3];
            self_refresh_enable_q <= i_hwdata[DRT_F_SLF];
            post_sr_precharge_q <= i_hwdata[DRT_F_TPCS+:3];
            match_irq_enable_q <= i_hwdata[DRT_F_MIE] && !i_hwdata[DRT_F_RFE];
        end
        else if (refresh_enable_q)
            match_irq_enable_q <= 1'b0;
    end

    // Match flag, the set wins over a clear
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            match_flag_q <= 1'b0;
        else if (match)
            match_flag_q <= 1'b1;
        else if (wr_en && wr_addr == DRT_IDX_IRQ_CLEAR && i_hwdata[0])
            match_flag_q <= 1'b0;
        else if (wr_en && wr_addr == DRT_IDX_REFCTL && !i_hwdata[DRT_F_FLAG])
            match_flag_q <= 1'b0;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            irq_enable_q <= 1'b1;
        else if (wr_en && wr_addr == DRT_IDX_IRQ_ENABLE)
            irq_enable_q <= i_hwdata[0];
    end

    // Interval interrupt only when refresh is off
    assign o_irq = match_flag_q && match_irq_enable_q && !refresh_enable_q && irq_enable_q;

    // System and DRAM control
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            ext_bus_en_q <= 1'b0;
        else if (i_expansion_mode)
            ext_bus_en_q <= 1'b1;
        else if (wr_en && wr_addr == DRT_IDX_SYSCTL)
            ext_bus_en_q <= i_hwdata[DRT_F_EXTERNAL_BUS_ENABLE];
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            precharge_cycles_q <= '0;
            memory_output_enable_q <= 1'b0;
        end
        else if (wr_en && wr_addr == DRT_IDX_DRAMCTL)
        begin
            precharge_cycles_q <= i_hwdata[DRT_F_TPC+:2];
            memory_output_enable_q <= i_hwdata[DRT_F_OEE];
        end
    end

    // ==========================================================
    // Memory sequencer
    drt_mem_state_t state_q;
    logic [3:0] prech_cnt_q;
    logic pending_q;
    logic sr_go;

    // Refresh and self-refresh need the external bus enabled
    assign sr_go = i_standby_req && self_refresh_enable_q && refresh_enable_q && ext_bus_en_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            pending_q <= 1'b0;
        else if (match && refresh_enable_q)
            pending_q <= 1'b1;
        else if (state_q == DRT_MEM_REFRESH)
            pending_q <= 1'b0;
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            state_q <= DRT_MEM_RUN;
            prech_cnt_q <= '0;
        end
        else
        begin
            unique case (state_q)
                DRT_MEM_RUN:
                begin
                    if (sr_go)
                        state_q <= DRT_MEM_SELFREF;
                    else if (pending_q && ext_bus_en_q)
                        state_q <= DRT_MEM_REFRESH;
                end
                DRT_MEM_REFRESH:
                begin
                    if (i_refresh_done)
                        state_q <= DRT_MEM_RUN;
                end
                DRT_MEM_SELFREF:
                begin
                    if (!i_standby_req)
                    begin
                        state_q <= DRT_MEM_PRECHG;
                        prech_cnt_q <= 4'({1'b0, post_sr_precharge_q} + {2'b00, precharge_cycles_q});
                    end
                end
                DRT_MEM_PRECHG:
                begin
                    if (prech_cnt_q == 4'h0)
                        state_q <= DRT_MEM_RUN;
                    else
                        prech_cnt_q <= prech_cnt_q - 4'h1;
                end
            endcase
        end
    end

    drt_mem_ctl_t mem_q;

    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            mem_q <= '0;
        else
        begin
            mem_q.refresh_req <= state_q == DRT_MEM_REFRESH;
            mem_q.self_refresh <= state_q == DRT_MEM_SELFREF;
            mem_q.refresh_wait <= refresh_wait_q;
            mem_q.post_sr_precharge <= {3'b000, state_q == DRT_MEM_PRECHG};
            mem_q.ext_bus_en <= ext_bus_en_q;
            mem_q.cke_oe <= memory_output_enable_q;
        end
    end

    assign o_refresh = mem_q.refresh_req;
    assign o_self_refresh = mem_q.self_refresh;
    assign o_precharge = mem_q.post_sr_precharge[0];
    assign o_refresh_wait = mem_q.refresh_wait;
    assign o_ext_bus_en = mem_q.ext_bus_en;
    assign o_cke_oe = mem_q.cke_oe;

    // ==========================================================
    // Read data
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn)
            o_hrdata <= '0;
        else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite)
        begin
            unique case (i_haddr[25:2])
                DRT_IDX_COUNTER: o_hrdata <= {24'h00_0000, counter_q};
                DRT_IDX_CONSTANT: o_hrdata <= {24'h00_0000, constant_q};
                DRT_IDX_SYSCTL: o_hrdata <= 32'(ext_bus_en_q) << DRT_F_EXTERNAL_BUS_ENABLE;
                DRT_IDX_REFCTL: o_hrdata <= {16'h0000, match_flag_q, match_irq_enable_q, 3'b000, clock_sel_q,
                    refresh_enable_q, refresh_wait_q, self_refresh_enable_q, post_sr_precharge_q};
                DRT_IDX_IRQ_STATUS: o_hrdata <= {31'h0000_0000, match_flag_q};
                DRT_IDX_IRQ_ENABLE: o_hrdata <= {31'h0000_0000, irq_enable_q};
                DRT_IDX_DRAMCTL: o_hrdata <= {16'h0000, 2'b00, precharge_cycles_q, 11'h000, memory_output_enable_q};
                DRT_IDX_STANDBY: o_hrdata <= {28'h000_0000, 2'(state_q), o_self_refresh, o_refresh};
                default: o_hrdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule

// ==== sim/drt_refresh_timer_sva.sv ====
// Purpose: Port checker for the refresh timer block
// Assumes: One clock, synchronous active-low reset
// Notes: Control fields are internal, so only port relations are held here
`timescale 1ns/100ps
module drt_refresh_timer_sva (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Bus
    input wire logic i_hsel,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic o_hreadyout,
    input wire logic o_hresp,
    // Memory side
    input wire logic i_expansion_mode,
    input wire logic i_standby_req,
    input wire logic i_refresh_done,
    input wire logic o_refresh,
    input wire logic o_self_refresh,
    input wire logic o_precharge,
    input wire logic o_ext_bus_en,
    input wire logic o_irq
);
    // ==========================================================
    // Properties
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rstn);
    logic wr;
    // A write lands one cycle after its address phase, so two cycles are excused
    assign wr = i_hsel && i_htrans[1] && i_hwrite;
    a_okay_zero_wait: assert property (o_hreadyout && !o_hresp)
        else $error("bus response not ready or not okay");
    // The forced bit reaches the pin two cycles after the mode is seen
    a_bus_forced: assert property (i_expansion_mode && $past(i_expansion_mode) && $past(i_expansion_mode, 2) |-> o_ext_bus_en)
        else $error("external bus enable not forced in expansion mode");
    // The request pin lags the sequencer, so it may stand one cycle past done
    a_refresh_holds: assert property (o_refresh && !i_refresh_done && !$past(i_refresh_done) |=> o_refresh)
        else $error("refresh cycle dropped before done");
    a_refresh_needs_bus: assert property ($rose(o_refresh) |-> o_ext_bus_en)
        else $error("refresh started with external bus off");
    a_selfref_on_standby: assert property ($rose(o_self_refresh) |-> $past(i_standby_req))
        else $error("self-refresh entered without standby");
    a_selfref_leaves: assert property (o_self_refresh && !i_standby_req |-> ##[1:8] !o_self_refresh)
        else $error("self-refresh held after standby ended");
    a_precharge_after: assert property ($rose(o_precharge) |-> $past(o_self_refresh) || $past(o_self_refresh, 2))
        else $error("precharge without preceding self-refresh");
    a_irq_sticky: assert property (o_irq && !wr && !$past(wr) |=> o_irq)
        else $error("interrupt dropped without a register write");
    c_irq: cover property ($rose(o_irq));
    c_refresh: cover property ($rose(o_refresh));
    c_precharge: cover property ($rose(o_precharge));
endmodule
bind drt_refresh_timer drt_refresh_timer_sva u_sva (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_hsel(i_hsel),
    .i_htrans(i_htrans), .i_hwrite(i_hwrite), .o_hreadyout(o_hreadyout), .o_hresp(o_hresp),
    .i_expansion_mode(i_expansion_mode), .i_standby_req(i_standby_req), .i_refresh_done(i_refresh_done),
    .o_refresh(o_refresh), .o_self_refresh(o_self_refresh), .o_precharge(o_precharge),
    .o_ext_bus_en(o_ext_bus_en), .o_irq(o_irq));

// ==== sim/drt_mem_model.sv ====
// Purpose: External memory answering refresh cycles
// Assumes: Refresh request is a level held until done
// Notes: Slow mode stretches the answer to stress the hold of the request
`timescale 1ns/100ps
module drt_mem_model (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rstn,
    // Refresh handshake
    input wire logic i_refresh,
    input wire logic [2:0] i_wait,
    input wire logic i_slow,
    output logic o_done
);
    // ==========================================================
    // Refresh answer
    logic [3:0] cnt_q;
    always_ff @(posedge i_sys_clk)
    begin
        if (!i_rstn || !i_refresh)
        begin
            cnt_q <= 4'h0;
            o_done <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_q + 4'h1;
            o_done <= (cnt_q == {1'b0, i_wait} + (i_slow ? 4'h6 : 4'h1));
        end
    end
endmodule

// ==== sim/dram_refresh_timer_control_tb_top.sv ====
// Purpose: Self-checking bench for the refresh timer block
// Assumes: Zero-wait bus slave, registered read data
// Notes: Byte address is the register index times four
`timescale 1ns/100ps
module dram_refresh_timer_control_tb_top;
    import drt_pkg::*;
    // ==========================================================
    // Signals
    logic clk, rstn, exp_mode, standby, slow, done, irq, refr, selfr, prech, bus_en, cke;
    logic hready, hresp;
    logic [2:0] rwait;
    logic [31:0] hwdata, hrdata, rd;
    drt_ahb_req_t req;
    int fails, check_count;
    wire [3:0] watch = {prech, selfr, refr, irq};
    drt_refresh_timer dut (.i_sys_clk(clk), .i_rstn(rstn), .i_hsel(1'b1), .i_haddr(req.haddr),
        .i_htrans(req.htrans), .i_hwrite(req.hwrite), .i_hsize(req.hsize), .i_hwdata(hwdata), .i_hready(hready),
        .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp), .i_expansion_mode(exp_mode),
        .i_standby_req(standby), .i_refresh_done(done), .o_refresh(refr), .o_self_refresh(selfr),
        .o_precharge(prech), .o_refresh_wait(rwait), .o_ext_bus_en(bus_en), .o_cke_oe(cke), .o_irq(irq));
    drt_mem_model mem (.i_sys_clk(clk), .i_rstn(rstn), .i_refresh(refr), .i_wait(rwait), .i_slow(slow),
        .o_done(done));
    // ==========================================================
    // Shared tasks
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            $display("mismatch %s expected %h seen %h", name, exp, seen);
            fails++;
        end
    endtask
    task automatic wait_lvl(input int sel, input logic v);
        int n;
        n = 0;
        while (watch[sel] !== v && n < 400)
        begin
            @(posedge clk);
            n++;
        end
        if (n == 400)
        begin
            fails++;
            give_verdict();
        end
    endtask
    // Master holds each phase until it samples ready high
    task automatic bus(input logic w, input logic [23:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{2'b10, w, 3'b010, {6'h00, idx, 2'b00}};
        do @(posedge clk); while (hready !== 1'b1 && ++n < 64);
        req.htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1 && ++n < 64);
        rd = hrdata;
        chk("bus_resp", {31'h0, hresp}, 32'h0);
        if (n >= 64)
        begin
            fails++;
            give_verdict();
        end
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset_values();
        bus(0, DRT_IDX_REFCTL, 0);
        chk("ctl_reset", rd, 32'h0000_0180);
        bus(0, DRT_IDX_CONSTANT, 0);
        chk("constant_reset", rd, {24'h0, DRT_RST_CONSTANT});
        bus(0, DRT_IDX_SYSCTL, 0);
        chk("sysctl_bus_reset", {31'h0, rd[DRT_F_EXTERNAL_BUS_ENABLE]}, 32'h0);
        bus(0, 24'h00_0001, 0);
        chk("unmapped", rd, 32'h0);
        bus(1, DRT_IDX_REFCTL, 32'h0000_4180);
        bus(0, DRT_IDX_REFCTL, 0);
        chk("irq_en_locked", rd, 32'h0000_0180);
    endtask
    task automatic t_interval();
        logic [31:0] c1;
        bus(1, DRT_IDX_CONSTANT, 32'h0000_0003);
        // Restart the count below the constant, or it must wrap past 255 first
        bus(1, DRT_IDX_COUNTER, 32'h0000_0000);
        bus(1, DRT_IDX_REFCTL, 32'h0000_4100);
        wait_lvl(0, 1);
        repeat (12) @(posedge clk);
        chk("irq_sticky", {31'h0, irq}, 32'h1);
        bus(0, DRT_IDX_IRQ_STATUS, 0);
        chk("flag_set", rd, 32'h1);
        bus(0, DRT_IDX_COUNTER, 0);
        chk("counter_range", {31'h0, rd <= 32'h3}, 32'h1);
        bus(1, DRT_IDX_IRQ_ENABLE, 32'h0);
        @(posedge clk);
        chk("irq_masked", {31'h0, irq}, 32'h0);
        bus(1, DRT_IDX_IRQ_ENABLE, 32'h1);
        bus(1, DRT_IDX_REFCTL, 32'h0000_8000);
        bus(0, DRT_IDX_IRQ_STATUS, 0);
        chk("flag_kept", rd, 32'h1);
        bus(0, DRT_IDX_COUNTER, 0);
        c1 = rd;
        bus(1, DRT_IDX_IRQ_CLEAR, 32'h1);
        bus(0, DRT_IDX_COUNTER, 0);
        chk("counter_stopped", rd, c1);
        bus(1, DRT_IDX_REFCTL, 32'h0000_c000);
        bus(0, DRT_IDX_IRQ_STATUS, 0);
        chk("flag_cleared", rd, 32'h0);
        chk("irq_no_flag", {31'h0, irq}, 32'h0);
    endtask
    task automatic t_refresh();
        bus(1, DRT_IDX_SYSCTL, 32'h0000_0200);
        bus(1, DRT_IDX_REFCTL, 32'h0000_01a0);
        repeat (2) @(posedge clk);
        chk("wait_field", {29'h0, rwait}, 32'h2);
        wait_lvl(1, 1);
        chk("bus_enabled", {31'h0, bus_en}, 32'h1);
        slow <= 1'b1;
        wait_lvl(1, 0);
        wait_lvl(1, 1);
        wait_lvl(1, 0);
        chk("no_irq_refresh", {31'h0, irq}, 32'h0);
        slow <= 1'b0;
    endtask
    task automatic t_self_refresh();
        int c;
        bus(1, DRT_IDX_DRAMCTL, 32'h0000_1001);
        bus(1, DRT_IDX_REFCTL, 32'h0000_01aa);
        chk("cke_enabled", {31'h0, cke}, 32'h1);
        standby <= 1'b1;
        wait_lvl(2, 1);
        standby <= 1'b0;
        wait_lvl(3, 1);
        c = 0;
        do
        begin
            c++;
            @(posedge clk);
        end
        while (watch[3] === 1'b1 && c < 20);
        chk("precharge_len", c, 2 + 1 + 1);
    endtask
    task automatic t_expansion();
        exp_mode <= 1'b1;
        bus(1, DRT_IDX_SYSCTL, 32'h0);
        chk("bus_forced", {31'h0, bus_en}, 32'h1);
        exp_mode <= 1'b0;
        bus(1, DRT_IDX_REFCTL, 32'h0000_0100);
        bus(1, DRT_IDX_SYSCTL, 32'h0);
        repeat (2) @(posedge clk);
        chk("bus_off", {31'h0, bus_en}, 32'h0);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {rstn, exp_mode, standby, slow, hwdata, fails, check_count} = '0;
        req = '{2'b00, 1'b0, 3'b010, 32'h0};
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        t_reset_values();
        t_interval();
        t_refresh();
        t_self_refresh();
        t_expansion();
        give_verdict();
    end
endmodule
